// ==== pkg/b3r_pkg.sv ====
/*
  Shared constants for the third buck regulator and backup supply register bank:
  register offsets, field positions, writable and fuse-loaded masks, reset values,
  the operating-mode type and the masked merge used for every control and backup register update.
  Assumes an 8-bit register port on the device's internal host bus.
*/
package b3r_pkg;

  localparam int REG_W = 8;
  localparam int CODE_W_DEF = 4;
  localparam int SYNC_STAGES = 2;

  // register offsets
  localparam logic [7:0] ADDR_RUN_VOLT = 8'h3e;
  localparam logic [7:0] ADDR_STBY_VOLT = 8'h3f;
  localparam logic [7:0] ADDR_SLP_VOLT = 8'h40;
  localparam logic [7:0] ADDR_CTRL = 8'h41;
  localparam logic [7:0] ADDR_CTRL1 = 8'h42;
  localparam logic [7:0] ADDR_BACKUP = 8'h48;

  // buck3_control fields
  localparam int CTRL_RUN_EN = 0;
  localparam int CTRL_STBY_EN = 1;
  localparam int CTRL_SLP_EN = 2;
  localparam int CTRL_LPWR = 3;
  localparam int CTRL_FPWM = 6;
  localparam int CTRL_DIS_OFF = 7;

  // buck3_control_second fields
  localparam int CTRL1_ILIM_LSB = 0;
  localparam int CTRL1_ILIM_W = 2;
  localparam int CTRL1_TMODE = 4;

  // backup_supply_control fields
  localparam int BKP_VOLT_LSB = 0;
  localparam int BKP_VOLT_W = 3;
  localparam int BKP_EVAL = 3;
  localparam int BKP_FORCE_BOS = 4;
  localparam int BKP_BG_DIS = 5;

  // implemented bits; all others read zero and ignore writes
  localparam logic [7:0] CTRL_WMASK = 8'hcf;
  localparam logic [7:0] CTRL1_WMASK = 8'h13;
  localparam logic [7:0] BACKUP_WMASK = 8'h3f;

  // bits that take their value from the fuses at power-up
  localparam logic [7:0] CTRL_FUSE_MASK = 8'h83;
  localparam logic [7:0] CTRL1_FUSE_MASK = 8'h03;
  localparam logic [7:0] BACKUP_FUSE_MASK = 8'h07;

  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] BACKUP_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  typedef enum logic [1:0] {
    B3R_MODE_RUN,
    B3R_MODE_STANDBY,
    B3R_MODE_SLEEP,
    B3R_MODE_OFF
  } b3r_mode_t;

  // replace the bits under mask, keep the rest
  function automatic logic [7:0] b3r_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                           input logic [7:0] mask);
    b3r_merge = (old_v & ~mask) | (new_v & mask);
  endfunction

endpackage

// ==== pkg/b3r_fuse_if.sv ====
/*
  Carrier for the captured fuse image between the fuse loader and the register bank.
  Assumes both ends run on clk_sys; load is a one-cycle pulse.
*/
`timescale 1ns/1ps
interface b3r_fuse_if #(parameter int CODE_W = 4);
  logic load;
  logic [7:0] ctrl;
  logic [7:0] ctrl1;
  logic [7:0] backup;
  logic [CODE_W-1:0] run_code;
  logic [CODE_W-1:0] stby_code;
  logic [CODE_W-1:0] slp_code;

  modport src (output load, ctrl, ctrl1, backup, run_code, stby_code, slp_code);
  modport dst (input load, ctrl, ctrl1, backup, run_code, stby_code, slp_code);
endinterface

// ==== rtl/b3r_fuse_loader.sv ====
/*
  Fuse loader: captures the fuse image on the rising edge of fuse_valid and
  issues a one-cycle load pulse to the register bank.
  Assumes the fuse controller runs on clk_sys and holds its words while valid is high.
*/
`timescale 1ns/1ps
module b3r_fuse_loader
  import b3r_pkg::*;
#(
  parameter int CODE_W = CODE_W_DEF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // fuse controller
  input wire logic fuse_valid,
  input wire logic [7:0] fuse_ctrl,
  input wire logic [7:0] fuse_ctrl1,
  input wire logic [7:0] fuse_backup,
  input wire logic [CODE_W-1:0] fuse_run_code,
  input wire logic [CODE_W-1:0] fuse_stby_code,
  input wire logic [CODE_W-1:0] fuse_slp_code,
  // captured image
  b3r_fuse_if.src fuse
);

  logic valid_d_r;
  logic take;

  assign take = fuse_valid & ~valid_d_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      valid_d_r <= 1'b0;
      fuse.load <= 1'b0;
    end else begin
      valid_d_r <= fuse_valid;
      fuse.load <= take;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fuse.ctrl <= CTRL_RST;
      fuse.ctrl1 <= CTRL1_RST;
      fuse.backup <= BACKUP_RST;
      fuse.run_code <= '0;
      fuse.stby_code <= '0;
      fuse.slp_code <= '0;
    end else if (take) begin
      fuse.ctrl <= fuse_ctrl;
      fuse.ctrl1 <= fuse_ctrl1;
      fuse.backup <= fuse_backup;
      fuse.run_code <= fuse_run_code;
      fuse.stby_code <= fuse_stby_code;
      fuse.slp_code <= fuse_slp_code;
    end
  end

endmodule

// ==== rtl/b3r_regs.sv ====
/*
  Register bank for the third buck regulator and the coin-cell backed supply,
  with the per-mode selection of enable, voltage code and low-power state.
  Assumes a host-bus slave on clk_sys issuing one-cycle reg_wr / reg_rd strobes,
  a fuse controller on clk_sys, and asynchronous analogue comparator levels.
*/
// Overview of operation
// - run enable loads from fuses; software clears to turn off, sets to turn on
// - control bit 1 enables regulator in standby, resets 0, software may clear
// - control bit 2 read/write, resets 0, enables regulator in sleep
// - control bit 3 selects low-power state during standby or sleep
// - control bit 6 forces continuous PWM regardless of load
// - control bit 7 clear connects discharge resistor while disabled; set leaves it off
// - two-bit current limit in second control register, codes 00 to 11, resets 00
// - second control bit 4 picks on-time (0) or off-time (1) control
// - three four-bit voltage codes come from fuses; software writes never change them
// - voltage code applied follows current mode: run, standby or sleep
// - backup voltage field bits 2..0 writable, resets 000, drives nothing
// - backup bit 4 forces best-supply selector, else active only on low rail
// - backup bit 5 disables backup band-gap while on coin cell
// - backup bit 3 evaluation bit, read/write, resets 0
// - fuse-loaded control and backup fields take fuse value at power-up, then software read/write
`timescale 1ns/1ps
module b3r_regs
  import b3r_pkg::*;
#(
  parameter int CODE_W = CODE_W_DEF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // host register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // fuse controller
  input wire logic fuse_valid,
  input wire logic [7:0] fuse_ctrl,
  input wire logic [7:0] fuse_ctrl1,
  input wire logic [7:0] fuse_backup,
  input wire logic [CODE_W-1:0] fuse_run_code,
  input wire logic [CODE_W-1:0] fuse_stby_code,
  input wire logic [CODE_W-1:0] fuse_slp_code,
  // operating state
  input wire b3r_mode_t op_mode,
  input wire logic system_rail_low,
  input wire logic coin_cell_mode,
  // regulator controls
  output logic buck3_enable,
  output logic [CODE_W-1:0] buck3_voltage_code,
  output logic buck3_low_power,
  output logic buck3_forced_pwm,
  output logic buck3_discharge_connect,
  output logic [CTRL1_ILIM_W-1:0] buck3_current_limit,
  output logic buck3_timing_scheme_select,
  // backup supply controls
  output logic best_supply_active,
  output logic backup_bandgap_enable,
  output logic evaluation_pulse_bit
);

  b3r_fuse_if #(.CODE_W(CODE_W)) fuse ();

  b3r_fuse_loader #(.CODE_W(CODE_W)) u_loader (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .fuse_valid(fuse_valid),
    .fuse_ctrl(fuse_ctrl),
    .fuse_ctrl1(fuse_ctrl1),
    .fuse_backup(fuse_backup),
    .fuse_run_code(fuse_run_code),
    .fuse_stby_code(fuse_stby_code),
    .fuse_slp_code(fuse_slp_code),
    .fuse(fuse)
  );

  // register state
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] ctrl1_r, ctrl1_nxt;
  logic [7:0] backup_r, backup_nxt;
  logic [CODE_W-1:0] run_code_r, stby_code_r, slp_code_r;

  // comparator synchronisers
  logic [1:0] async_in;
  logic [1:0] sync1_r, sync2_r;
  logic rail_low_s, coin_cell_s;

  // decode
  logic wr_ctrl, wr_ctrl1, wr_backup;
  logic [7:0] read_word;
  logic [7:0] code_word;
  logic low_power_mode;

  // next outputs
  logic enable_nxt;
  logic [CODE_W-1:0] code_nxt;

  assign wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;
  assign wr_ctrl1 = reg_wr && reg_addr == ADDR_CTRL1;
  assign wr_backup = reg_wr && reg_addr == ADDR_BACKUP;

  // fuse load wins over a host write in the same cycle
  assign ctrl_nxt = fuse.load ? b3r_merge(ctrl_r, fuse.ctrl, CTRL_FUSE_MASK) :
                    wr_ctrl ? b3r_merge(ctrl_r, reg_wdata, CTRL_WMASK) : ctrl_r;
  assign ctrl1_nxt = fuse.load ? b3r_merge(ctrl1_r, fuse.ctrl1, CTRL1_FUSE_MASK) :
                     wr_ctrl1 ? b3r_merge(ctrl1_r, reg_wdata, CTRL1_WMASK) : ctrl1_r;
  assign backup_nxt = fuse.load ? b3r_merge(backup_r, fuse.backup, BACKUP_FUSE_MASK) :
                      wr_backup ? b3r_merge(backup_r, reg_wdata, BACKUP_WMASK) : backup_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RST;
      ctrl1_r <= CTRL1_RST;
      backup_r <= BACKUP_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      ctrl1_r <= ctrl1_nxt;
      backup_r <= backup_nxt;
    end
  end

  // voltage codes change only on a fuse load, never from the host
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      run_code_r <= '0;
      stby_code_r <= '0;
      slp_code_r <= '0;
    end else if (fuse.load) begin
      run_code_r <= fuse.run_code;
      stby_code_r <= fuse.stby_code;
      slp_code_r <= fuse.slp_code;
    end
  end

  assign async_in = {coin_cell_mode, system_rail_low};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  assign rail_low_s = sync2_r[0];
  assign coin_cell_s = sync2_r[1];

  // read decode; unused bits are never stored, so they read zero
  assign code_word = 8'(reg_addr == ADDR_RUN_VOLT ? run_code_r :
                        reg_addr == ADDR_STBY_VOLT ? stby_code_r : slp_code_r);
  assign read_word = (reg_addr == ADDR_RUN_VOLT || reg_addr == ADDR_STBY_VOLT ||
                      reg_addr == ADDR_SLP_VOLT) ? code_word :
                     reg_addr == ADDR_CTRL ? (ctrl_r & CTRL_WMASK) :
                     reg_addr == ADDR_CTRL1 ? (ctrl1_r & CTRL1_WMASK) :
                     reg_addr == ADDR_BACKUP ? (backup_r & BACKUP_WMASK) : 8'h00;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= RDATA_RST;
    end else if (reg_rd) begin
      reg_rdata <= read_word;
    end
  end

  // per-mode selection of enable and voltage code
  always_comb begin
    enable_nxt = 1'b0;
    code_nxt = run_code_r;
    unique case (op_mode)
      B3R_MODE_RUN: begin
        enable_nxt = ctrl_r[CTRL_RUN_EN];
        code_nxt = run_code_r;
      end
      B3R_MODE_STANDBY: begin
        enable_nxt = ctrl_r[CTRL_STBY_EN];
        code_nxt = stby_code_r;
      end
      B3R_MODE_SLEEP: begin
        enable_nxt = ctrl_r[CTRL_SLP_EN];
        code_nxt = slp_code_r;
      end
      B3R_MODE_OFF: begin
        enable_nxt = 1'b0;
        code_nxt = run_code_r;
      end
    endcase
  end

  assign low_power_mode = op_mode == B3R_MODE_STANDBY || op_mode == B3R_MODE_SLEEP;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      buck3_enable <= 1'b0;
      buck3_voltage_code <= '0;
      buck3_low_power <= 1'b0;
      buck3_forced_pwm <= 1'b0;
      buck3_discharge_connect <= 1'b0;
      buck3_current_limit <= '0;
      buck3_timing_scheme_select <= 1'b0;
      best_supply_active <= 1'b0;
      backup_bandgap_enable <= 1'b1;
      evaluation_pulse_bit <= 1'b0;
    end else begin
      buck3_enable <= enable_nxt;
      buck3_voltage_code <= code_nxt;
      buck3_low_power <= ctrl_r[CTRL_LPWR] & low_power_mode;
      buck3_forced_pwm <= ctrl_r[CTRL_FPWM];
      buck3_discharge_connect <= ~ctrl_r[CTRL_DIS_OFF] & ~enable_nxt;
      buck3_current_limit <= ctrl1_r[CTRL1_ILIM_LSB +: CTRL1_ILIM_W];
      buck3_timing_scheme_select <= ctrl1_r[CTRL1_TMODE];
      best_supply_active <= backup_r[BKP_FORCE_BOS] | rail_low_s;
      backup_bandgap_enable <= ~(backup_r[BKP_BG_DIS] & coin_cell_s);
      evaluation_pulse_bit <= backup_r[BKP_EVAL];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  run_enable_a: assert property ((op_mode == B3R_MODE_RUN) |=> buck3_enable == $past(ctrl_r[0]))
    else $error("run-mode enable does not follow control bit 0");
  standby_enable_a: assert property ((op_mode == B3R_MODE_STANDBY) ##1 1'b1
    |-> buck3_enable == $past(ctrl_r[1]))
    else $error("standby enable does not follow control bit 1");
  sleep_enable_a: assert property ((op_mode == B3R_MODE_SLEEP && !ctrl_r[2]) |=> !buck3_enable)
    else $error("regulator enabled in sleep with bit 2 clear");
  low_power_a: assert property ((ctrl_r[3] && op_mode == B3R_MODE_RUN) |=> !buck3_low_power)
    else $error("low-power state asserted in run mode");
  forced_pwm_a: assert property ($rose(ctrl_r[6]) |-> ##1 buck3_forced_pwm)
    else $error("forced PWM did not follow control bit 6");
  discharge_path_a: assert property (buck3_discharge_connect |-> !buck3_enable && !$past(ctrl_r[7]))
    else $error("discharge resistor connected while enabled or disabled by bit 7");
  current_limit_a: assert property ((wr_ctrl1 && !fuse.load)
    |=> ##1 buck3_current_limit == $past(reg_wdata[1:0], 2))
    else $error("current limit field did not take written code");
  timing_select_a: assert property ((wr_ctrl1 && !fuse.load) |=> ctrl1_r[4] == $past(reg_wdata[4]))
    else $error("timing scheme bit did not take written value");
  code_lock_a: assert property (!fuse.load |=> $stable(run_code_r) && $stable(stby_code_r)
    && $stable(slp_code_r))
    else $error("voltage code changed without fuse load");
  applied_code_a: assert property ((op_mode == B3R_MODE_STANDBY)
    |=> buck3_voltage_code == $past(stby_code_r))
    else $error("standby voltage code not applied");
  bos_force_a: assert property ((backup_r[4] || rail_low_s) |=> best_supply_active)
    else $error("best-supply selector not active");
  bandgap_off_a: assert property ((backup_r[5] && coin_cell_s) |=> !backup_bandgap_enable)
    else $error("backup band-gap left on in coin-cell mode");
  unused_zero_a: assert property (reg_rd |=> (reg_rdata & ~BACKUP_WMASK) == 8'h00 ||
    $past(reg_addr) != ADDR_BACKUP)
    else $error("unused backup bits read non-zero");

  stby_on_a: assert property ((op_mode == B3R_MODE_STANDBY && ctrl_r[CTRL_STBY_EN]) |=> buck3_enable)
    else $error("standby enable not raised with bit 1 set");
  sleep_on_a: assert property ((op_mode == B3R_MODE_SLEEP && ctrl_r[CTRL_SLP_EN]) |=> buck3_enable)
    else $error("sleep enable not raised with bit 2 set");
  low_power_on_a: assert property (
    (ctrl_r[CTRL_LPWR] && op_mode inside {B3R_MODE_STANDBY, B3R_MODE_SLEEP}) |=> buck3_low_power)
    else $error("low-power state missing in standby or sleep");
  pwm_off_a: assert property (!ctrl_r[CTRL_FPWM] |=> !buck3_forced_pwm)
    else $error("forced PWM set while control bit 6 clear");
  discharge_on_a: assert property ((!ctrl_r[CTRL_DIS_OFF] && op_mode == B3R_MODE_OFF)
    |=> buck3_discharge_connect)
    else $error("discharge resistor not connected in off mode");
  discharge_off_a: assert property (ctrl_r[CTRL_DIS_OFF] |=> !buck3_discharge_connect)
    else $error("discharge resistor connected with bit 7 set");
  ilim_out_a: assert property (buck3_current_limit == $past(ctrl1_r[CTRL1_ILIM_LSB +: CTRL1_ILIM_W]))
    else $error("current limit output does not follow its field");
  timing_out_a: assert property (buck3_timing_scheme_select == $past(ctrl1_r[CTRL1_TMODE]))
    else $error("timing scheme output does not follow its bit");
  run_code_a: assert property ((op_mode == B3R_MODE_RUN) |=> buck3_voltage_code == $past(run_code_r))
    else $error("run voltage code not applied");
  sleep_code_a: assert property ((op_mode == B3R_MODE_SLEEP)
    |=> buck3_voltage_code == $past(slp_code_r))
    else $error("sleep voltage code not applied");
  off_mode_a: assert property ((op_mode == B3R_MODE_OFF)
    |=> !buck3_enable && buck3_voltage_code == $past(run_code_r))
    else $error("off mode output wrong");
  ctrl_write_a: assert property ((wr_ctrl && !fuse.load) |=> ctrl_r == $past(reg_wdata & CTRL_WMASK))
    else $error("control register did not take written value");
  ctrl1_write_a: assert property ((wr_ctrl1 && !fuse.load) |=> ctrl1_r == $past(reg_wdata & CTRL1_WMASK))
    else $error("second control register kept unused bits");
  bkp_write_a: assert property ((wr_backup && !fuse.load)
    |=> backup_r == $past(reg_wdata & BACKUP_WMASK))
    else $error("backup register did not take written value");
  eval_bit_a: assert property ((wr_backup && !fuse.load)
    |=> ##1 evaluation_pulse_bit == $past(reg_wdata[BKP_EVAL], 2))
    else $error("evaluation bit output did not take written value");
  bos_idle_a: assert property ((!backup_r[BKP_FORCE_BOS] && !rail_low_s) |=> !best_supply_active)
    else $error("best-supply selector active without cause");
  bandgap_on_a: assert property (!coin_cell_s |=> backup_bandgap_enable)
    else $error("backup band-gap off outside coin-cell mode");
  fuse_ctrl_a: assert property (fuse.load
    |=> (ctrl_r & CTRL_FUSE_MASK) == $past(fuse.ctrl & CTRL_FUSE_MASK))
    else $error("fuse-loaded control bits did not take the fuse image");
  fuse_keep_a: assert property (fuse.load
    |=> (ctrl_r & ~CTRL_FUSE_MASK) == $past(ctrl_r & ~CTRL_FUSE_MASK))
    else $error("fuse load touched plain control bits");
  fuse_code_a: assert property (fuse.load |=> run_code_r == $past(fuse.run_code) &&
    stby_code_r == $past(fuse.stby_code) && slp_code_r == $past(fuse.slp_code))
    else $error("voltage codes did not take the fuse image");
  unused_ctrl_a: assert property ((reg_rd && reg_addr == ADDR_CTRL)
    |=> (reg_rdata & ~CTRL_WMASK) == 8'h00)
    else $error("unused control bits read non-zero");
  unmapped_read_a: assert property ((reg_rd && reg_addr > ADDR_CTRL1 && reg_addr != ADDR_BACKUP)
    |=> reg_rdata == 8'h00)
    else $error("unmapped address read non-zero");
  code_read_a: assert property ((reg_rd && reg_addr == ADDR_RUN_VOLT)
    |=> reg_rdata == 8'($past(run_code_r)))
    else $error("run voltage code read back wrong");
  rdata_bkp_a: assert property ((reg_rd && reg_addr == ADDR_BACKUP) |=> reg_rdata == $past(backup_r))
    else $error("backup register read back wrong");

endmodule

// ==== sim/b3r_regs_tb.sv ====
/*
  Self-checking bench for b3r_regs: fuse loads, register reads and writes,
  and the per-mode regulator and backup supply outputs.
  Assumes the register bank alone on clk_sys at 250 MHz, with no other bus.
*/
`timescale 1ns/1ps
module b3r_regs_tb;
  import b3r_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic fuse_valid = 1'b0;
  logic [7:0] fuse_ctrl = 8'h00;
  logic [7:0] fuse_ctrl1 = 8'h00;
  logic [7:0] fuse_backup = 8'h00;
  logic [3:0] fuse_run_code = 4'h0;
  logic [3:0] fuse_stby_code = 4'h0;
  logic [3:0] fuse_slp_code = 4'h0;
  b3r_mode_t op_mode = B3R_MODE_RUN;
  logic system_rail_low = 1'b0;
  logic coin_cell_mode = 1'b0;
  logic buck3_enable, buck3_low_power, buck3_forced_pwm, buck3_discharge_connect;
  logic buck3_timing_scheme_select, best_supply_active, backup_bandgap_enable, evaluation_pulse_bit;
  logic [3:0] buck3_voltage_code;
  logic [1:0] buck3_current_limit;
  wire logic [13:0] outs = {buck3_enable, buck3_voltage_code, buck3_low_power, buck3_forced_pwm,
    buck3_discharge_connect, buck3_current_limit, buck3_timing_scheme_select, best_supply_active,
    backup_bandgap_enable, evaluation_pulse_bit};
  int mismatches = 0;
  int checks_done = 0;
  integer seed = 86856;
  logic [7:0] m_ctrl = 8'h00;
  logic [7:0] m_ctrl1 = 8'h00;
  logic [7:0] m_bkp = 8'h00;
  logic [3:0] m_code [3] = '{4'h0, 4'h0, 4'h0};
  logic [7:0] addr_tab [8] = '{ADDR_RUN_VOLT, ADDR_STBY_VOLT, ADDR_SLP_VOLT, ADDR_CTRL, ADDR_CTRL1,
    ADDR_BACKUP, 8'h43, 8'hff};

  b3r_regs #(.CODE_W(4)) uut (.*);

  always #2 clk_sys = ~clk_sys;

  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    case (a)
      ADDR_RUN_VOLT: exp_reg = {4'h0, m_code[0]};
      ADDR_STBY_VOLT: exp_reg = {4'h0, m_code[1]};
      ADDR_SLP_VOLT: exp_reg = {4'h0, m_code[2]};
      ADDR_CTRL: exp_reg = m_ctrl;
      ADDR_CTRL1: exp_reg = m_ctrl1;
      ADDR_BACKUP: exp_reg = m_bkp;
      default: exp_reg = 8'h00;
    endcase
  endfunction

  function automatic logic [13:0] exp_out(input b3r_mode_t md);
    logic en;
    logic [3:0] cd;
    logic lp;
    case (md)
      B3R_MODE_RUN: begin en = m_ctrl[0]; cd = m_code[0]; end
      B3R_MODE_STANDBY: begin en = m_ctrl[1]; cd = m_code[1]; end
      B3R_MODE_SLEEP: begin en = m_ctrl[2]; cd = m_code[2]; end
      default: begin en = 1'b0; cd = m_code[0]; end
    endcase
    lp = m_ctrl[3] & (md == B3R_MODE_STANDBY || md == B3R_MODE_SLEEP);
    exp_out = {en, cd, lp, m_ctrl[6], ~m_ctrl[7] & ~en, m_ctrl1[1:0], m_ctrl1[4],
      m_bkp[4] | system_rail_low, ~(m_bkp[5] & coin_cell_mode), m_bkp[3]};
  endfunction

  task automatic chk_reg(input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD reg t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_out(input logic [13:0] e, input logic [13:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD out t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1 reg_wr = 1'b0;
    if (a == ADDR_CTRL) m_ctrl = d & CTRL_WMASK;
    if (a == ADDR_CTRL1) m_ctrl1 = d & CTRL1_WMASK;
    if (a == ADDR_BACKUP) m_bkp = d & BACKUP_WMASK;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk_sys);
    #1 reg_rd = 1'b0;
    @(posedge clk_sys);
    #1 d = reg_rdata;
  endtask

  task automatic read_all();
    logic [7:0] d;
    foreach (addr_tab[i]) begin
      bus_rd(addr_tab[i], d);
      chk_reg(exp_reg(addr_tab[i]), d);
    end
  endtask

  task automatic check_modes();
    logic [13:0] e;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys);
      #1 op_mode = b3r_mode_t'(m[1:0]);
      repeat (3) @(posedge clk_sys);
      #1 e = exp_out(op_mode);
      chk_out(e & 14'h3f00, outs & 14'h3f00);
      chk_out(e & 14'h00ff, outs & 14'h00ff);
    end
  endtask

  // a fresh rising edge of fuse_valid; valid then stays high
  task automatic fuse_load(input logic ones);
    @(posedge clk_sys);
    #1 fuse_valid = 1'b0;
    @(posedge clk_sys);
    #1 fuse_ctrl = ones ? 8'hff : 8'($random(seed));
    fuse_ctrl1 = ones ? 8'hff : 8'($random(seed));
    fuse_backup = ones ? 8'hff : 8'($random(seed));
    fuse_run_code = ones ? 4'hf : 4'($random(seed));
    fuse_stby_code = ones ? 4'hf : 4'($random(seed));
    fuse_slp_code = ones ? 4'hf : 4'($random(seed));
    fuse_valid = 1'b1;
    m_ctrl = (m_ctrl & ~CTRL_FUSE_MASK) | (fuse_ctrl & CTRL_FUSE_MASK);
    m_ctrl1 = (m_ctrl1 & ~CTRL1_FUSE_MASK) | (fuse_ctrl1 & CTRL1_FUSE_MASK);
    m_bkp = (m_bkp & ~BACKUP_FUSE_MASK) | (fuse_backup & BACKUP_FUSE_MASK);
    m_code = '{fuse_run_code, fuse_stby_code, fuse_slp_code};
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic finish_test();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    finish_test();
  end

  initial begin
    logic [7:0] a;
    logic [7:0] d;
    int r;
    repeat (16) @(posedge clk_sys);
    #1 resetn = 1'b1;
    check_modes();
    read_all();
    fuse_load(1'b0);
    read_all();
    check_modes();
    // all ones, then all zeros, to every place incl. read-only and unmapped
    foreach (addr_tab[i]) bus_wr(addr_tab[i], 8'hff);
    read_all();
    check_modes();
    foreach (addr_tab[i]) bus_wr(addr_tab[i], 8'h00);
    read_all();
    check_modes();
    for (int k = 0; k < 40; k++) begin
      r = $random(seed);
      @(posedge clk_sys);
      #1 {system_rail_low, coin_cell_mode} = r[1:0];
      a = addr_tab[r[4:2]];
      bus_wr(a, 8'($random(seed)));
      bus_rd(a, d);
      chk_reg(exp_reg(a), d);
      check_modes();
    end
    fuse_load(1'b1);
    read_all();
    check_modes();
    finish_test();
  end
endmodule
